// ---- src/rsi_pkg.sv ----
// Package for the reset strap and init mode block: register map, field
// positions, reset values and the strap carrier struct.
// Assumes a 32-bit AXI4-Lite register bus and one clock domain.
package rsi_pkg;

	localparam int          RSI_AXI_AW       = 4;
	localparam int          RSI_AXI_DW       = 32;

	// Register byte offsets
	localparam logic [3:0]  RSI_OFF_CTRL     = 4'h0;
	localparam logic [3:0]  RSI_OFF_STRAP    = 4'h4;
	localparam logic [3:0]  RSI_OFF_GATE     = 4'h8;
	localparam logic [3:0]  RSI_OFF_ID       = 4'hc;

	// Control/status fields (offset 0x0)
	localparam int          RSI_CTRL_CORE    = 0;
	localparam int          RSI_CTRL_RETRY   = 1;
	localparam int          RSI_CTRL_HELD    = 2;
	localparam int          RSI_CTRL_PRST    = 3;

	// Strap readout fields (offset 0x4)
	localparam int          RSI_STRAP_MODE   = 0;
	localparam int          RSI_STRAP_SLOT   = 2;
	localparam int          RSI_STRAP_NIC    = 3;

	// Select gate fields (offset 0x8)
	localparam int          RSI_GATE_SLOT    = 0;
	localparam int          RSI_GATE_NIC     = 1;

	// Reset values
	localparam logic        RSI_RST_CORE_BIT = 1'b0;
	localparam logic        RSI_RST_RETRY    = 1'b1;
	localparam logic [1:0]  RSI_RST_GATE     = 2'h0;
	localparam logic [31:0] RSI_RST_ID       = 32'h0000_5a01; // Arbitrary value

	// Init mode encodings: {core_hold, cfg_retry}
	localparam logic [1:0]  RSI_MODE_DEFAULT = 2'h3;

	localparam logic [1:0]  RSI_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RSI_RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic core_hold;
		logic cfg_retry;
		logic slot_select_gate_en;
		logic nic_select_gate_en;
	} rsi_straps_t;

	// Default straps: core runs, retry on, both select gates off
	localparam rsi_straps_t RSI_STRAPS_DEFAULT = '{1'b1, 1'b1, 1'b0, 1'b0};

	typedef enum logic [1:0] {
		RSI_BUS_IN_RESET,
		RSI_BUS_RELEASING,
		RSI_BUS_RUNNING
	} rsi_bus_state_t;

endpackage

// ---- src/rsi_strap_latch.sv ----
// Strap latch: catches the board straps on the release of the primary
// bus reset. Assumes p_rst_n and straps are synchronous to aclk.
`timescale 1ns/1ps

module rsi_strap_latch
	import rsi_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        p_rst_n,
	input  wire rsi_straps_t straps_in,
	output rsi_straps_t      straps_cap,
	output logic             released,
	output logic             bus_low
);

	logic        p_rst_n_reg;
	rsi_straps_t cap_reg;
	rsi_straps_t cap_next;
	logic        rel_reg;
	logic        rise;

	// Release edge: low last cycle, high now
	assign rise     = ~p_rst_n_reg & p_rst_n;
	assign cap_next = rise ? straps_in : cap_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p_rst_n_reg <= 1'b0;
			cap_reg     <= RSI_STRAPS_DEFAULT;
			rel_reg     <= 1'b0;
		end else begin
			p_rst_n_reg <= p_rst_n;
			cap_reg     <= cap_next; // [R1] [R3]
			rel_reg     <= rise;
		end
	end

	assign straps_cap = cap_reg;
	assign released   = rel_reg;
	assign bus_low    = ~p_rst_n_reg;

endmodule

// ---- src/rsi_top.sv ----
// Reset strap and init mode controller with an AXI4-Lite register slave.
// Assumes straps, primary bus reset and config requests are synchronous
// to aclk, and that the far side keeps straps steady across reset release.
`timescale 1ns/1ps

// How it works
// R1: Core-hold strap is caught when primary bus reset releases, kept until next reset.
// R2: Caught core-hold 0 keeps core in reset until software clears core-reset bit.
// R3: Retry strap is caught on primary bus reset release, kept until next reset.
// R4: Retry strap 1 with retry bit set answers every config cycle with Retry.
// R5: Init mode is the pair core-hold, retry; mode 3 is the default.
// R6: Slot select gate enabled lets a processor output hide the expansion slot.
// R7: NIC select gate enabled lets a processor output hide the NIC; both default off.
// R8: Board keeps each private/public select routing pair at opposite values.
// R9: Straps stay steady through reset and across its release edge.
module rsi_top
	import rsi_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Primary bus reset and straps
	input  wire logic        p_rst_n,
	input  wire logic        core_hold_strap,
	input  wire logic        cfg_retry_strap,
	input  wire logic        slot_select_gate_en,
	input  wire logic        nic_select_gate_en,
	// Core reset out
	output logic             core_rst_n,
	// Config transaction terminator
	input  wire logic        cfg_req,
	output logic             cfg_done,
	output logic             cfg_retry,
	// Select lines to the secondary bus devices
	input  wire logic        slot_idsel_in,
	input  wire logic        nic_idsel_in,
	output logic             slot_idsel_out,
	output logic             nic_idsel_out,
	output logic [1:0]       init_mode,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// Identification word; value is arbitrary
	parameter logic [31:0] ID_VALUE = RSI_RST_ID;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Write-zero-to-clear for one bit, set wins over clear
	function automatic logic w0c(input logic cur, input logic hit,
	                             input logic wbit, input logic set);
		w0c = set | (cur & ~(hit & ~wbit));
	endfunction

	// Known word offsets
	function automatic logic mapped(input logic [3:0] a);
		mapped = (a == RSI_OFF_CTRL) | (a == RSI_OFF_STRAP) |
		         (a == RSI_OFF_GATE) | (a == RSI_OFF_ID);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Strap capture

	rsi_straps_t straps_raw;
	rsi_straps_t cap;
	logic        released;
	logic        bus_low;

	// Straps are sampled once per release; the board keeps them still
	// across that edge, so no second look is taken
	assign straps_raw = '{core_hold_strap, cfg_retry_strap,
	                      slot_select_gate_en, nic_select_gate_en};

	rsi_strap_latch u_latch (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.p_rst_n    (p_rst_n),
		.straps_in  (straps_raw),
		.straps_cap (cap),
		.released   (released),
		.bus_low    (bus_low)
	);

	////////////////////////////////////////////////////////////////////////
	// Primary bus reset tracking

	// The middle state spans the gap while the caught straps settle in
	rsi_bus_state_t bus_state_reg;
	rsi_bus_state_t bus_state_next;
	logic           bus_held;

	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			RSI_BUS_IN_RESET: begin
				if (p_rst_n)
					bus_state_next = RSI_BUS_RELEASING;
			end
			RSI_BUS_RELEASING: begin
				bus_state_next = p_rst_n ? RSI_BUS_RUNNING : RSI_BUS_IN_RESET;
			end
			RSI_BUS_RUNNING: begin
				if (!p_rst_n)
					bus_state_next = RSI_BUS_IN_RESET;
			end
			default: begin
				bus_state_next = RSI_BUS_IN_RESET;
			end
		endcase
	end

	// Status bit: anything short of running counts as in reset
	assign bus_held = (bus_state_reg != RSI_BUS_RUNNING);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path

	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        wr_go;
	logic        wr_ok;
	logic        wr_ctrl;
	logic        wr_gate;

	// Fields live in byte lane 0 only; the other lanes are dropped
	// Address and data are taken together in one beat; a lone one waits
	assign wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
	assign wr_ok   = mapped(s_axi_awaddr);
	assign wr_ctrl = wr_go & (s_axi_awaddr == RSI_OFF_CTRL) & s_axi_wstrb[0];
	assign wr_gate = wr_go & (s_axi_awaddr == RSI_OFF_GATE) & s_axi_wstrb[0];

	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RSI_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_ok ? RSI_RESP_OKAY : RSI_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control bits

	logic       core_bit_reg;
	logic       core_bit_next;
	logic       retry_bit_reg;
	logic       retry_bit_next;
	logic [1:0] gate_reg;
	logic [1:0] gate_next;

	// The release pulse arms the bits from the caught straps; a software
	// clear landing in that same cycle loses so the hold is never skipped.
	// The core bit is reloaded on every release, not only set: a hold left
	// from an earlier bus session must not outlive a caught strap of 1
	assign core_bit_next  = released ? ~cap.core_hold :
	                        w0c(core_bit_reg, wr_ctrl,
	                            s_axi_wdata[RSI_CTRL_CORE], 1'b0); // [R2]
	// A caught retry strap of 0 leaves the bit alone; retry_now is gated
	// by the strap anyway, so a stale bit cannot retry
	assign retry_bit_next = w0c(retry_bit_reg, wr_ctrl,
	                            s_axi_wdata[RSI_CTRL_RETRY],
	                            released & cap.cfg_retry); // [R4]
	assign gate_next      = wr_gate ? s_axi_wdata[1:0] : gate_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_bit_reg  <= RSI_RST_CORE_BIT;
			retry_bit_reg <= RSI_RST_RETRY;
			gate_reg      <= RSI_RST_GATE;
			bus_state_reg <= RSI_BUS_IN_RESET;
		end else begin
			core_bit_reg  <= core_bit_next;
			retry_bit_reg <= retry_bit_next;
			gate_reg      <= gate_next;
			bus_state_reg <= bus_state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core reset, config terminator, select lines

	logic       core_rst_n_reg;
	logic       core_held;
	logic       cfg_done_reg;
	logic       cfg_retry_reg;
	logic       retry_now;
	logic       slot_idsel_reg;
	logic       nic_idsel_reg;
	logic       slot_idsel_next;
	logic       nic_idsel_next;

	// Held through the bus reset and the capture gap, then by the bit
	assign core_held = ~p_rst_n | bus_low | core_bit_next; // [R2]

	// Every request is answered one cycle later; there is no back-pressure
	// Retry needs only the bit and the caught strap; the bus reset state is not looked at
	assign retry_now = retry_bit_reg & cap.cfg_retry; // [R4]

	// Gate enabled: processor output can pull the select low to hide
	// Hiding only ever pulls a select low; it never raises one
	assign slot_idsel_next = slot_idsel_in &
	                         ~(cap.slot_select_gate_en & gate_reg[RSI_GATE_SLOT]); // [R6]
	assign nic_idsel_next  = nic_idsel_in &
	                         ~(cap.nic_select_gate_en & gate_reg[RSI_GATE_NIC]); // [R7]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_rst_n_reg <= 1'b0;
			cfg_done_reg   <= 1'b0;
			cfg_retry_reg  <= 1'b0;
			slot_idsel_reg <= 1'b0;
			nic_idsel_reg  <= 1'b0;
		end else begin
			core_rst_n_reg <= ~core_held;
			cfg_done_reg   <= cfg_req;
			cfg_retry_reg  <= cfg_req & retry_now; // [R4]
			slot_idsel_reg <= slot_idsel_next;
			nic_idsel_reg  <= nic_idsel_next;
		end
	end

	assign core_rst_n     = core_rst_n_reg;
	assign cfg_done       = cfg_done_reg;
	assign cfg_retry      = cfg_retry_reg;
	assign slot_idsel_out = slot_idsel_reg;
	assign nic_idsel_out  = nic_idsel_reg;
	assign init_mode      = {cap.core_hold, cap.cfg_retry}; // [R5]

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        rd_go;
	logic [31:0] ctrl_word;
	logic [31:0] strap_word;
	logic [31:0] gate_word;
	logic [31:0] rd_word;

	// Unmapped offsets read as zero and answer SLVERR
	assign rd_go = s_axi_arvalid & ~rvalid_reg;

	assign ctrl_word  = {28'h0000000,
	                     bus_held,
	                     ~core_rst_n_reg,
	                     retry_bit_reg,
	                     core_bit_reg};
	assign strap_word = {28'h0000000, cap.nic_select_gate_en,
	                     cap.slot_select_gate_en, init_mode}; // [R5]
	assign gate_word  = {30'h00000000, gate_reg};

	assign rd_word = (s_axi_araddr == RSI_OFF_CTRL)  ? ctrl_word  :
	                 (s_axi_araddr == RSI_OFF_STRAP) ? strap_word :
	                 (s_axi_araddr == RSI_OFF_GATE)  ? gate_word  :
	                 (s_axi_araddr == RSI_OFF_ID)    ? ID_VALUE   :
	                 32'h00000000;

	assign s_axi_arready = rd_go;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= RSI_RESP_OKAY;
		end else if (rd_go) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_word;
			rresp_reg  <= mapped(s_axi_araddr) ? RSI_RESP_OKAY : RSI_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule

// ---- tb/rsi_chk_sva.sv ----
// Port assertions for the strap and init mode block.
// Assumes it is bound onto rsi_top, one clock domain.
`timescale 1ns/1ps

module rsi_chk (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       p_rst_n,
	input wire logic       core_hold_strap,
	input wire logic       cfg_retry_strap,
	input wire logic       core_rst_n,
	input wire logic       cfg_req,
	input wire logic       cfg_done,
	input wire logic       cfg_retry,
	input wire logic       slot_idsel_in,
	input wire logic       nic_idsel_in,
	input wire logic       slot_idsel_out,
	input wire logic       nic_idsel_out,
	input wire logic [1:0] init_mode
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_done; cfg_req |=> cfg_done; endproperty
	a_done: assert property (p_done) else $error("request unanswered");
	// A caught retry strap of 0 must never retry, whatever the bit says
	property p_retry; cfg_req && !init_mode[0] |=> !cfg_retry; endproperty
	a_retry: assert property (p_retry) else $error("retry without strap");
	property p_cap; $rose(p_rst_n) |=> init_mode == {$past(core_hold_strap), $past(cfg_retry_strap)}; endproperty
	a_cap: assert property (p_cap) else $error("mode not caught");
	property p_core_low; !p_rst_n |=> !core_rst_n; endproperty
	a_core_low: assert property (p_core_low) else $error("core out of reset");
	property p_core_rise; $rose(p_rst_n) && core_hold_strap |=> ##1 core_rst_n; endproperty
	a_core_rise: assert property (p_core_rise) else $error("core not started");
	property p_core_hold; $rose(p_rst_n) && !core_hold_strap |=> !core_rst_n [*3]; endproperty
	a_core_hold: assert property (p_core_hold) else $error("core not held");
	property p_slot; slot_idsel_out |-> $past(slot_idsel_in); endproperty
	a_slot: assert property (p_slot) else $error("slot select invented");
	property p_nic; nic_idsel_out |-> $past(nic_idsel_in); endproperty
	a_nic: assert property (p_nic) else $error("nic select invented");

	c_retry: cover property (cfg_done && cfg_retry);
	c_start: cover property ($rose(core_rst_n));
	c_hide: cover property ($past(slot_idsel_in) && !slot_idsel_out);
endmodule

bind rsi_top rsi_chk u_chk (
	.aclk            (aclk),
	.aresetn         (aresetn),
	.p_rst_n         (p_rst_n),
	.core_hold_strap (core_hold_strap),
	.cfg_retry_strap (cfg_retry_strap),
	.core_rst_n      (core_rst_n),
	.cfg_req         (cfg_req),
	.cfg_done        (cfg_done),
	.cfg_retry       (cfg_retry),
	.slot_idsel_in   (slot_idsel_in),
	.nic_idsel_in    (nic_idsel_in),
	.slot_idsel_out  (slot_idsel_out),
	.nic_idsel_out   (nic_idsel_out),
	.init_mode       (init_mode)
);

// ---- tb/rsi_host_model.sv ----
// Host side model: bus reset, board straps and config requests.
// Assumes the same clock as the block; requests are one-cycle pulses.
`timescale 1ns/1ps

module rsi_host_model
	import rsi_pkg::*;
(
	input  wire logic   aclk,
	output logic        p_rst_n,
	output rsi_straps_t straps,
	output logic        cfg_req,
	input  wire logic   cfg_done,
	input  wire logic   cfg_retry
);
	initial begin
		p_rst_n = 1'h0;
		straps = RSI_STRAPS_DEFAULT;
		cfg_req = 1'h0;
	end

	// Straps move only inside reset and stay put across release
	task automatic bus_reset(input rsi_straps_t s);
		@(posedge aclk);
		p_rst_n <= 1'h0;
		straps <= s;
		repeat (4) @(posedge aclk);
		p_rst_n <= 1'h1;
		repeat (4) @(posedge aclk);
	endtask

	// Back to back requests; answers are counted as they come
	task automatic cfg_burst(input int n, output int n_retry, output int n_done);
		n_retry = 0;
		n_done = 0;
		for (int i = 0; i < n + 2; i++) begin
			@(posedge aclk);
			cfg_req <= (i < n);
			if (cfg_done === 1'h1) n_done++;
			if (cfg_done === 1'h1 && cfg_retry === 1'h1) n_retry++;
		end
	endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench: modes, core hold, retry, select gating, registers.
// Assumes the host model drives bus reset, straps and config requests.
`timescale 1ns/1ps

module tb;
	import rsi_pkg::*;
	logic        aclk = 1'h0, aresetn = 1'h0, slot_idsel_in = 1'h0, nic_idsel_in = 1'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, init_mode;
	logic        p_rst_n, cfg_req, cfg_done, cfg_retry, core_rst_n, slot_idsel_out, nic_idsel_out;
	rsi_straps_t straps;
	wire logic   core_hold_strap = straps.core_hold;
	wire logic   cfg_retry_strap = straps.cfg_retry;
	wire logic   slot_select_gate_en = straps.slot_select_gate_en;
	wire logic   nic_select_gate_en = straps.nic_select_gate_en;
	int          num_errors = 0, n_checks = 0;

	always #25 aclk = ~aclk;

	rsi_top DUT (.*);
	rsi_host_model host (.aclk(aclk), .p_rst_n(p_rst_n), .straps(straps), .cfg_req(cfg_req),
		.cfg_done(cfg_done), .cfg_retry(cfg_retry));

	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Every aligned word of the 16-byte window is a register
	function automatic logic [1:0] exp_resp(input logic [3:0] a);
		exp_resp = (a[1:0] == 2'h0) ? RSI_RESP_OKAY : RSI_RESP_SLVERR;
	endfunction

	// A select is hidden only when the caught strap and the gate bit are both set
	function automatic logic exp_sel(input logic in, input logic en, input logic hide);
		exp_sel = (en && hide) ? 1'b0 : in;
	endfunction

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		check(32'(s_axi_bresp), 32'(exp_resp(a)));
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		check(32'(s_axi_rresp), 32'(exp_resp(a)));
		d = s_axi_rdata;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  m, g, h, sel;
		int          nr, nd;
		void'($urandom(32'heed5));
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		check(32'(core_rst_n), 32'h0);
		check(32'(init_mode), 32'(RSI_MODE_DEFAULT));
		for (int i = 0; i < 8; i++) begin
			m = 2'(i);
			g = 2'($urandom);
			host.bus_reset({m[1], m[0], g[0], g[1]});
			check(32'(init_mode), 32'(m));
			rd(RSI_OFF_STRAP, d);
			check(d & 32'hf, {28'h0, g[1], g[0], m});
			check(32'(core_rst_n), 32'(m[1]));
			host.cfg_burst(3, nr, nd);
			check(32'(nr), m[0] ? 32'h3 : 32'h0);
			check(32'(nd), 32'h3);
			// Clearing both bits releases the core and opens config cycles
			wr(RSI_OFF_CTRL, 32'h0);
			repeat (2) @(posedge aclk);
			check(32'(core_rst_n), 32'h1);
			rd(RSI_OFF_CTRL, d);
			check(d, 32'h0);
			host.cfg_burst(2, nr, nd);
			check(32'(nd - nr), 32'h2);
			h = 2'($urandom);
			sel = 2'($urandom);
			wr(RSI_OFF_GATE, 32'(h));
			// Routing pairs stay opposite on the board, so selects arrive only this way
			slot_idsel_in <= sel[0];
			nic_idsel_in <= sel[1];
			repeat (2) @(posedge aclk);
			check(32'(slot_idsel_out), 32'(exp_sel(sel[0], g[0], h[0])));
			check(32'(nic_idsel_out), 32'(exp_sel(sel[1], g[1], h[1])));
			$display("test %0d done, mode %0d", i, m);
		end
		rd(RSI_OFF_ID, d);
		check(d, RSI_RST_ID);
		// Unmapped offsets answer SLVERR; a write with lane 0 masked is dropped
		rd(RSI_OFF_GATE, d);
		wr(4'h6, 32'hffffffff);
		s_axi_wstrb <= 4'he;
		wr(RSI_OFF_GATE, ~d);
		s_axi_wstrb <= 4'hf;
		rd(RSI_OFF_GATE, e);
		check(e, d);
		rd(4'h6, e);
		check(e, 32'h0);
		$display("test corners done");
		results();
	end

	// Whole run is under a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		results();
	end
endmodule
